/* common/pcint_pkg.sv */
/*
  package for the pin change interrupt block: register offsets, field
  layout, reset values and the bus request carrier.
  assumes a plain 8-bit register port with read data one cycle later.
*/
package pcint_pkg;
  localparam int PCINT_PINS = 6;
  localparam int PCINT_AW = 4;
  localparam int PCINT_DW = 8;
  localparam logic [3:0] OFF_RISE_EN = 4'h0;
  localparam logic [3:0] OFF_FALL_EN = 4'h1;
  localparam logic [3:0] OFF_FLAGS = 4'h2;
  localparam logic [3:0] OFF_CTRL = 4'h3;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'h5;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h6;
  localparam logic [5:0] PIN_FIELD_RESET = 6'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_SUMMARY_BIT = 1;
  localparam int EVT_EDGE_BIT = 0;
  localparam int EVT_WAKE_BIT = 1;
  localparam int EVT_WIDTH = 2;
  localparam logic [1:0] EVT_RESET = 2'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pcint_req_t;

  typedef enum logic [0:0] {
    PCINT_AWAKE = 1'b0,
    PCINT_ASLEEP = 1'b1
  } pcint_pwr_t;
endpackage

/* rtl/pcint_edge.sv */
/*
  per-pin edge detector giving one-cycle rise and fall pulses.
  assumes its input is already synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pcint_edge #(
  parameter int W = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  // edges are held off until the synchroniser has flushed its reset zeros,
  // so a pin already high at release is not taken for a rise
  localparam int SETTLE = 3;

  logic [W-1:0] prev;
  logic [SETTLE-1:0] arm;
  logic primed;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
      arm <= '0;
    end else begin
      prev <= level;
      arm <= {arm[SETTLE-2:0], 1'b1};
    end
  end

  assign primed = arm[SETTLE-1];

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      assign rise[i] = primed & level[i] & ~prev[i];
      assign fall[i] = primed & ~level[i] & prev[i];
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/pcint_sync.sv */
/*
  two flip-flop synchroniser, one stage pair per pin.
  assumes pins may change at any time relative to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pcint_sync #(
  parameter int W = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

/* rtl/pcint_top.sv */
/*
  pin change interrupt block: six port pins watched for enabled edges,
  sticky change flags, summary interrupt with master enable, sleep wake.
  assumes a plain synchronous register port; pins may be asynchronous.
*/
// Our own choices: the address-and-strobe port and the address map.
// Contract
// - rising edge detected only when enabled
// - falling edge detected only when enabled
// - flag sets on any enabled edge
// - software clears flag by writing zero
// - zero flag means none seen or cleared
// - master enable lets edge wake from sleep
// - flags updated before core resumes after wake
// - upper two bits read zero, ignore writes
// - enables and flags reset to zero
// - master clear still detects, no request; block_irq still asserts for an edge event enabled in evt_enable
// - summary is OR of six flags
// - edge during clear leaves flag set
`timescale 1ns/10ps
`default_nettype none
module pcint_top
  import pcint_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [pcint_pkg::PCINT_PINS-1:0] port_a_pin,
  input wire logic sleep_req,
  input wire logic [pcint_pkg::PCINT_AW-1:0] reg_addr,
  input wire logic [pcint_pkg::PCINT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcint_pkg::PCINT_DW-1:0] reg_rdata,
  output logic change_irq,
  output logic wake,
  output logic asleep,
  output logic block_irq
);
  import pcint_pkg::*;

  localparam int N = PCINT_PINS;

  pcint_req_t req;
  logic [N-1:0] pin_sync;
  logic [N-1:0] rise_pulse;
  logic [N-1:0] fall_pulse;
  logic [N-1:0] rise_edge_enable;
  logic [N-1:0] fall_edge_enable;
  logic [N-1:0] pin_change_flags;
  logic [N-1:0] hardware_set;
  logic [N-1:0] next_flags;
  logic change_irq_master_enable;
  logic change_irq_summary;
  logic [EVT_WIDTH-1:0] evt_status;
  logic [EVT_WIDTH-1:0] evt_enable;
  logic [EVT_WIDTH-1:0] evt_set;
  logic [EVT_WIDTH-1:0] next_evt;
  logic [PCINT_DW-1:0] next_rdata;
  logic wake_evt;
  pcint_pwr_t pwr_state;

  function automatic logic hit(input pcint_req_t r, input logic [3:0] off);
    hit = r.wr && (r.addr == off);
  endfunction

  function automatic logic [PCINT_DW-1:0] pad(input logic [N-1:0] v);
    pad = {{(PCINT_DW - N){1'b0}}, v};
  endfunction

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  pcint_sync #(.W(N)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(port_a_pin),
    .sync_out(pin_sync)
  );

  pcint_edge #(.W(N)) u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(pin_sync),
    .rise(rise_pulse),
    .fall(fall_pulse)
  );

  // detection runs whatever the master enable says
  assign hardware_set = (rise_pulse & rise_edge_enable)
                      | (fall_pulse & fall_edge_enable);

  // enable registers; upper bits are simply not stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_edge_enable <= PIN_FIELD_RESET;
      fall_edge_enable <= PIN_FIELD_RESET;
      change_irq_master_enable <= 1'b0;
    end else begin
      if (hit(req, OFF_RISE_EN)) begin
        rise_edge_enable <= req.wdata[N-1:0];
      end
      if (hit(req, OFF_FALL_EN)) begin
        fall_edge_enable <= req.wdata[N-1:0];
      end
      if (hit(req, OFF_CTRL)) begin
        change_irq_master_enable <= req.wdata[CTRL_MASTER_BIT];
      end
    end
  end

  // hardware set wins over a software write of zero
  always_comb begin
    next_flags = pin_change_flags;
    if (hit(req, OFF_FLAGS)) begin
      next_flags = req.wdata[N-1:0];
    end
    next_flags = next_flags | hardware_set;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_flags <= PIN_FIELD_RESET;
    end else begin
      pin_change_flags <= next_flags;
    end
  end

  assign change_irq_summary = |pin_change_flags;

  // sleep tracking: wake is raised only after flags hold the edge
  assign wake_evt = (pwr_state == PCINT_ASLEEP) && change_irq_master_enable
                  && change_irq_summary;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= PCINT_AWAKE;
    end else begin
      case (pwr_state)
        PCINT_AWAKE: begin
          if (sleep_req) begin
            pwr_state <= PCINT_ASLEEP;
          end
        end
        PCINT_ASLEEP: begin
          if (wake_evt) begin
            pwr_state <= PCINT_AWAKE;
          end
        end
        default: begin
          pwr_state <= PCINT_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= 1'b0;
      asleep <= 1'b0;
      change_irq <= 1'b0;
    end else begin
      wake <= wake_evt;
      asleep <= (pwr_state == PCINT_ASLEEP) && !wake_evt;
      // written master value counts at once, so clearing it leaves no stray cycle
      change_irq <= (hit(req, OFF_CTRL) ? req.wdata[CTRL_MASTER_BIT]
                     : change_irq_master_enable) && (|next_flags);
    end
  end

  // block-level event status: sticky, write-one-to-clear, set wins
  assign evt_set[EVT_EDGE_BIT] = |hardware_set;
  assign evt_set[EVT_WAKE_BIT] = wake_evt;

  always_comb begin
    next_evt = evt_status;
    if (hit(req, OFF_IRQ_CLEAR)) begin
      next_evt = evt_status & ~req.wdata[EVT_WIDTH-1:0];
    end
    next_evt = next_evt | evt_set;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= EVT_RESET;
      evt_enable <= EVT_RESET;
      block_irq <= 1'b0;
    end else begin
      evt_status <= next_evt;
      if (hit(req, OFF_IRQ_ENABLE)) begin
        evt_enable <= req.wdata[EVT_WIDTH-1:0];
      end
      block_irq <= |(next_evt & (hit(req, OFF_IRQ_ENABLE) ?
                   req.wdata[EVT_WIDTH-1:0] : evt_enable));
    end
  end

  // read decode; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = READ_ZERO;
    if (req.addr == OFF_RISE_EN) begin
      next_rdata = pad(rise_edge_enable);
    end else if (req.addr == OFF_FALL_EN) begin
      next_rdata = pad(fall_edge_enable);
    end else if (req.addr == OFF_FLAGS) begin
      next_rdata = pad(pin_change_flags);
    end else if (req.addr == OFF_CTRL) begin
      next_rdata[CTRL_MASTER_BIT] = change_irq_master_enable;
      next_rdata[CTRL_SUMMARY_BIT] = change_irq_summary;
    end else if (req.addr == OFF_IRQ_STATUS) begin
      next_rdata[EVT_WIDTH-1:0] = evt_status;
    end else if (req.addr == OFF_IRQ_ENABLE) begin
      next_rdata[EVT_WIDTH-1:0] = evt_enable;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end
endmodule
`default_nettype wire

/* sim/pcint_bench.sv */
/* self-checking bench for pcint_top.
   assumes the pin model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
module pcint_bench;
  import pcint_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_req = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [5:0] want = 6'h00;
  logic [5:0] port_a_pin;
  logic [7:0] reg_rdata;
  logic change_irq, wake, asleep, block_irq;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  pcint_pins pins (.want(want), .port_a_pin(port_a_pin));
  pcint_top dut (.core_clk(core_clk), .rst_n(rst_n), .port_a_pin(port_a_pin),
    .sleep_req(sleep_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .change_irq(change_irq), .wake(wake),
    .asleep(asleep), .block_irq(block_irq));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), exp, reg_rdata);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ceiling well above the roughly 125 cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), 8'h00);
    end
    $display("test reset done");
    wr(OFF_RISE_EN, 8'hFF);
    wr(OFF_FALL_EN, 8'hFF);
    rd(OFF_RISE_EN, 8'h3F);
    rd(OFF_FALL_EN, 8'h3F);
    wr(OFF_RISE_EN, 8'h15);
    wr(OFF_FALL_EN, 8'h26);
    want <= 6'h3F;
    waitc(8);
    rd(OFF_FLAGS, 8'h15);
    chk("change_irq", 8'h00, {7'h00, change_irq});
    want <= 6'h00;
    waitc(8);
    rd(OFF_FLAGS, 8'h37);
    rd(OFF_CTRL, 8'h02);
    wr(OFF_FLAGS, 8'h37 & ~8'h05);
    rd(OFF_FLAGS, 8'h32);
    wr(OFF_FLAGS, 8'h00);
    rd(OFF_CTRL, 8'h00);
    // write of zero lands in the cycle the rising edges set the flags
    @(posedge core_clk);
    want <= 6'h3F;
    @(posedge core_clk);
    wr(OFF_FLAGS, 8'h00);
    waitc(4);
    rd(OFF_FLAGS, 8'h15);
    $display("test edges done");
    wr(OFF_CTRL, 8'h01);
    chk("change_irq", 8'h01, {7'h00, change_irq});
    wr(OFF_FLAGS, 8'h00);
    @(posedge core_clk);
    sleep_req <= 1'b1;
    @(posedge core_clk);
    sleep_req <= 1'b0;
    waitc(1);
    chk("asleep", 8'h01, {7'h00, asleep});
    @(posedge core_clk);
    want <= 6'h00;
    for (int i = 0; i < 20 && wake !== 1'b1; i++) begin
      waitc(1);
    end
    chk("wake", 8'h01, {7'h00, wake});
    chk("asleep", 8'h00, {7'h00, asleep});
    rd(OFF_FLAGS, 8'h26);
    $display("test sleep done");
    wr(OFF_IRQ_ENABLE, 8'h01);
    chk("block_irq", 8'h01, {7'h00, block_irq});
    rd(OFF_IRQ_STATUS, 8'h03);
    wr(OFF_IRQ_ENABLE, 8'h00);
    chk("block_irq", 8'h00, {7'h00, block_irq});
    wr(OFF_IRQ_CLEAR, 8'h03);
    rd(OFF_IRQ_STATUS, 8'h00);
    rd(OFF_IRQ_CLEAR, 8'h00);
    wr(OFF_IRQ_ENABLE, 8'h03);
    chk("block_irq", 8'h00, {7'h00, block_irq});
    $display("test events done");
    end_sim();
  end
endmodule
`default_nettype wire

/* sim/pcint_pins.sv */
/* far-side model: external levels on the six port pins.
   assumes the bench holds each level two cycles or more. */
`timescale 1ns/10ps
`default_nettype none
module pcint_pins #(
  parameter realtime DLY = 1.0
) (
  input wire logic [5:0] want,
  output logic [5:0] port_a_pin
);
  // pins move off the clock edge, as an unrelated source would
  assign #(DLY) port_a_pin = want;
endmodule
`default_nettype wire

/* sim/pcint_props.sv */
/* port checker for pcint_top.
   assumes a bind onto pcint_top and a single core_clk domain. */
`timescale 1ns/10ps
`default_nettype none
module pcint_props
  import pcint_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sleep_req,
  input wire logic [pcint_pkg::PCINT_AW-1:0] reg_addr,
  input wire logic [pcint_pkg::PCINT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pcint_pkg::PCINT_DW-1:0] reg_rdata,
  input wire logic change_irq,
  input wire logic wake,
  input wire logic asleep
);
  logic master;
  // shadow of the master enable, since it is not a port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      master <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_CTRL) begin
      master <= reg_wdata[CTRL_MASTER_BIT];
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd_gap;
    reg_rd ##1 !reg_rd;
  endsequence
  // an immediate wake never shows asleep, so the sleep request counts too
  sequence s_woke;
    !asleep && ($past(asleep) || $past(sleep_req, 2));
  endsequence
  property p_top0;
    reg_rdata[7:6] == 2'b00;
  endproperty
  a_top0: assert property (p_top0) else $error("upper read bits set");
  property p_rd_stand;
    s_rd_gap |=> reg_rdata == 8'h00;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data lingers");
  property p_no_req;
    !master |-> !change_irq;
  endproperty
  a_no_req: assert property (p_no_req) else $error("irq without master");
  property p_irq_hold;
    change_irq && !reg_wr |=> change_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
  property p_wake;
    wake |-> (master and s_woke);
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_wake_one;
    wake |=> !wake;
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("wake too long");
  property p_wake_flags;
    wake |-> change_irq;
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("wake before flags");
  property p_sleep;
    sleep_req && !asleep |-> ##[1:2] (asleep || wake);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
endmodule
bind pcint_top pcint_props u_props (.core_clk(core_clk), .rst_n(rst_n), .sleep_req(sleep_req),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .change_irq(change_irq), .wake(wake), .asleep(asleep));
`default_nettype wire
